// ==== inc/amcg_cfg.svh ====
// audio master clock generator: offsets, field positions, reset values, timing counts
// assumes the APB slave decodes word addresses, byte address = 4 x register index
`ifndef AMCG_CFG_SVH
`define AMCG_CFG_SVH

// register indices, byte address is four times the index
`define AMCG_IDX_PLL_CTRL 8'h2b
`define AMCG_IDX_MCLK_SEL 8'h3a
`define AMCG_IDX_STATUS 8'h40

// audio_pll_control fields
`define AMCG_PLL_DIS_BIT 7
`define AMCG_PLL_CTRL_RST 8'h00

// master_clock_multiplier_select fields
`define AMCG_SEL_OVR_BIT 7
`define AMCG_SEL_FIELD_HI 6
`define AMCG_SEL_FIELD_LO 4
`define AMCG_MCLK_SEL_RST 8'h10

// status fields
`define AMCG_ST_LOCK_BIT 0
`define AMCG_ST_SLOW_BIT 1
`define AMCG_ST_BAND_LO 2
`define AMCG_ST_MULT_LO 4

// multiplier codes with special meaning
`define AMCG_CODE_TOP_X4 3'h6
`define AMCG_MULT_X2 2'h1

// system clock and bit clock band edges, in kHz
`define AMCG_CLK_KHZ 250000
`define AMCG_SLOW_KHZ 1000
`define AMCG_EDGE1_KHZ 1800
`define AMCG_EDGE2_KHZ 3800
`define AMCG_EDGE3_KHZ 7600
`define AMCG_SLOW_CYC (`AMCG_CLK_KHZ / `AMCG_SLOW_KHZ)
`define AMCG_EDGE1_CYC (`AMCG_CLK_KHZ / `AMCG_EDGE1_KHZ)
`define AMCG_EDGE2_CYC (`AMCG_CLK_KHZ / `AMCG_EDGE2_KHZ)
`define AMCG_EDGE3_CYC (`AMCG_CLK_KHZ / `AMCG_EDGE3_KHZ)

// loss of bit clock after this time, in ns
`define AMCG_TIMEOUT_NS 2000
`define AMCG_TIMEOUT_CYC ((`AMCG_TIMEOUT_NS * (`AMCG_CLK_KHZ / 1000)) / 1000)

// averaging window, log2 of bit clock periods
`define AMCG_WIN_LOG2 4

// link side reset stretch, released when the counter msb sets
`define AMCG_LINK_HOLD_W 11

`endif

// ==== inc/amcg_pkg.sv ====
// audio master clock generator: shared types
// assumes amcg_cfg.svh carries all numbers
package amcg_pkg;

  // bit clock rate band, selects the base code
  typedef enum logic [1:0] {BAND_LOW, BAND_MID, BAND_HIGH, BAND_TOP} amcg_band_t;

  // loop state
  typedef enum logic [1:0] {ST_OFF, ST_ACQUIRE, ST_LOCKED} amcg_state_t;

endpackage : amcg_pkg

// ==== logic/amcg_link_capture.sv ====
// audio master clock generator: logic on the audio bit clock
// assumes link_clock is the recovered bit clock, free of the system clock
`timescale 1ns/1ns
module amcg_link_capture (
  input wire logic link_clock, // audio bit clock
  input wire logic resetn, // system reset, synchronised here
  input wire logic audio_data, // serial audio data pin
  output logic edge_toggle, // flips on every bit clock rising edge
  output logic data_link // data sampled on the bit clock
);

  logic rst_meta;
  logic rst_sync;

  // reset release brought into the bit clock domain
  always_ff @(posedge link_clock)
  begin
    rst_meta <= resetn;
    rst_sync <= rst_meta;
  end

  // one toggle per bit clock period, crosses as an event
  always_ff @(posedge link_clock)
  begin
    if (!rst_sync)
      edge_toggle <= 1'b0;
    else
      edge_toggle <= ~edge_toggle;
  end

  // data capture, stable for a whole bit clock period
  always_ff @(posedge link_clock)
  begin
    if (!rst_sync)
      data_link <= 1'b0;
    else
      data_link <= audio_data;
  end

endmodule : amcg_link_capture

// ==== logic/amcg_top.sv ====
// audio master clock generator: jitter cleaning loop, master clock, APB registers
// assumes clock at 250 MHz, bit clock on link_clock, APB master on clock
//
// Notes on behaviour
// - a dedicated loop re-times the bit clock and data to cut jitter before output.
// - the master clock runs at one, two or four times the bit clock.
// - while the loop is disabled the master clock stays low.
// - after reset the master clock runs at twice the bit clock.
// - with override bit 7 set, the multiplier comes from the three-bit field in bits 6 to 4 of the select register, else it is x2.
// - below 1.8 MHz codes 000/001/010 are x1/x2/x4, higher rates shift the base up.
`timescale 1ns/1ns
`include "amcg_cfg.svh"
module amcg_top #(
  parameter int SPAN_W = 16, // width of the window counter
  parameter int TIMEOUT_CYC = `AMCG_TIMEOUT_CYC // cycles without a bit clock edge
) (
  input wire logic clock, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic link_clock, // audio bit clock
  input wire logic audio_data, // serial audio data in
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error
  output logic mclk, // master clock out
  output logic bclk_out, // cleaned bit clock out
  output logic data_out // re-timed data out
);

  localparam int WIN = 1 << `AMCG_WIN_LOG2;
  localparam logic [SPAN_W-1:0] STEP = SPAN_W'(WIN * 8);

  logic edge_toggle, data_link, tog_meta, tog_sync, tog_last, bclk_edge, data_retimed;
  logic pll_enable, span_valid, timeout, slow_clock, locked, tog4, sel_clk, hit, err_q;
  logic [7:0] pll_ctrl, mclk_sel, idx, rd_word;
  logic [SPAN_W-1:0] win_cnt, span, acc;
  logic [SPAN_W:0] acc_sum;
  logic [`AMCG_WIN_LOG2-1:0] edge_cnt;
  logic [`AMCG_LINK_HOLD_W-1:0] link_hold;
  logic [15:0] idle_cnt;
  logic [1:0] mult, cnt2;
  amcg_pkg::amcg_state_t state, next_state;
  amcg_pkg::amcg_band_t band;

  //--------------------------------------------------------------
  // link side and crossing
  //--------------------------------------------------------------

  // link side reset stretched past several edges of a slow bit clock
  always_ff @(posedge clock)
  begin
    if (!resetn)
      link_hold <= '0;
    else if (!link_hold[`AMCG_LINK_HOLD_W-1])
      link_hold <= link_hold + `AMCG_LINK_HOLD_W'(1);
  end

  // bit clock edges and data sampled in the link domain
  amcg_link_capture amcg_link_capture_inst (
    .link_clock(link_clock),
    .resetn(link_hold[`AMCG_LINK_HOLD_W-1]),
    .audio_data(audio_data),
    .edge_toggle(edge_toggle),
    .data_link(data_link)
  );

  // toggle synchroniser, edge found past the second stage
  always_ff @(posedge clock)
  begin
    tog_meta <= edge_toggle;
    tog_sync <= tog_meta;
    if (!resetn)
      tog_last <= 1'b0;
    else
      tog_last <= tog_sync;
  end
  assign bclk_edge = tog_sync ^ tog_last;

  // data taken once settled, when the synchronised bit clock edge that changed it is seen
  always_ff @(posedge clock)
  begin
    if (!resetn)
      data_retimed <= 1'b0;
    else if (bclk_edge)
      data_retimed <= data_link;
  end

  //--------------------------------------------------------------
  // period measurement
  //--------------------------------------------------------------

  // system cycles over a window of bit clock periods
  always_ff @(posedge clock)
  begin
    if (!resetn || !pll_enable || timeout)
    begin
      win_cnt <= '0;
      edge_cnt <= '0;
      span <= '0;
      span_valid <= 1'b0;
    end
    else if (bclk_edge && (edge_cnt == '1))
    begin
      span <= win_cnt + SPAN_W'(1);
      span_valid <= 1'b1;
      win_cnt <= '0;
      edge_cnt <= '0;
    end
    else
    begin
      win_cnt <= win_cnt + SPAN_W'(1);
      if (bclk_edge)
        edge_cnt <= edge_cnt + 1'b1;
    end
  end

  // watch for a stopped bit clock
  always_ff @(posedge clock)
  begin
    if (!resetn || bclk_edge)
      idle_cnt <= '0;
    else if (!timeout)
      idle_cnt <= idle_cnt + 16'h0001;
  end
  assign timeout = (idle_cnt == 16'(TIMEOUT_CYC));

  // rate band and slow clock flag from the mean period
  assign band = (span >= SPAN_W'(`AMCG_EDGE1_CYC * WIN)) ? amcg_pkg::BAND_LOW
    : (span >= SPAN_W'(`AMCG_EDGE2_CYC * WIN)) ? amcg_pkg::BAND_MID
    : (span >= SPAN_W'(`AMCG_EDGE3_CYC * WIN)) ? amcg_pkg::BAND_HIGH : amcg_pkg::BAND_TOP;
  assign slow_clock = span_valid && (span > SPAN_W'(`AMCG_SLOW_CYC * WIN));

  //--------------------------------------------------------------
  // loop state
  //--------------------------------------------------------------

  // acquire needs a full window, lock is lost on a stopped clock
  always_comb
  begin
    next_state = state;
    unique case (state)
      amcg_pkg::ST_OFF:
        if (pll_enable)
          next_state = amcg_pkg::ST_ACQUIRE;
      amcg_pkg::ST_ACQUIRE:
        if (span_valid)
          next_state = amcg_pkg::ST_LOCKED;
      amcg_pkg::ST_LOCKED:
        if (timeout)
          next_state = amcg_pkg::ST_ACQUIRE;
    endcase
    if (!pll_enable)
      next_state = amcg_pkg::ST_OFF;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      state <= amcg_pkg::ST_OFF;
    else
      state <= next_state;
  end
  assign locked = (state == amcg_pkg::ST_LOCKED);

  //--------------------------------------------------------------
  // multiplier decode
  //--------------------------------------------------------------

  // code relative to the band base, unknown codes keep x2
  always_comb
  begin
    logic [2:0] code;
    logic [2:0] rel;
    code = mclk_sel[`AMCG_SEL_FIELD_HI:`AMCG_SEL_FIELD_LO];
    rel = code - {1'b0, band};
    mult = `AMCG_MULT_X2;
    if (mclk_sel[`AMCG_SEL_OVR_BIT])
    begin
      if (band == amcg_pkg::BAND_TOP && code == `AMCG_CODE_TOP_X4)
        mult = 2'h2;
      else if (code >= {1'b0, band} && rel <= 3'h2)
        mult = rel[1:0];
    end
  end

  //--------------------------------------------------------------
  // clock synthesis
  //--------------------------------------------------------------

  // fractional divider at four times the bit clock, x2 and x1 count its falls
  assign acc_sum = {1'b0, acc} + {1'b0, STEP};
  always_ff @(posedge clock)
  begin
    if (!resetn || !locked)
    begin
      acc <= '0;
      tog4 <= 1'b0;
      cnt2 <= 2'h0;
    end
    else if (acc_sum >= {1'b0, span})
    begin
      acc <= SPAN_W'(acc_sum - {1'b0, span});
      tog4 <= ~tog4;
      if (tog4)
        cnt2 <= cnt2 + 2'h1;
    end
    else
      acc <= acc_sum[SPAN_W-1:0];
  end

  // selected clock
  assign sel_clk = (mult == 2'h0) ? cnt2[1] : ((mult == 2'h1) ? cnt2[0] : tog4);

  // mclk and bclk_out held low without lock or with the loop off
  always_ff @(posedge clock)
  begin
    if (!resetn || !locked)
    begin
      mclk <= 1'b0;
      bclk_out <= 1'b0;
    end
    else
    begin
      mclk <= sel_clk;
      bclk_out <= cnt2[1];
    end
  end

  // data launched on the falling clean bit clock
  always_ff @(posedge clock)
  begin
    if (!resetn)
      data_out <= 1'b0;
    else if (bclk_out && !cnt2[1])
      data_out <= data_retimed;
  end

  //--------------------------------------------------------------
  // apb registers
  //--------------------------------------------------------------

  assign idx = paddr[9:2];
  assign hit = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
    && (idx == `AMCG_IDX_PLL_CTRL || idx == `AMCG_IDX_MCLK_SEL || idx == `AMCG_IDX_STATUS);
  assign pll_enable = ~pll_ctrl[`AMCG_PLL_DIS_BIT];

  // register writes in the access phase
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pll_ctrl <= `AMCG_PLL_CTRL_RST;
      mclk_sel <= `AMCG_MCLK_SEL_RST;
    end
    else if (psel && penable && pwrite && pstrb[0])
    begin
      if (idx == `AMCG_IDX_PLL_CTRL && hit)
        pll_ctrl <= pwdata[7:0];
      if (idx == `AMCG_IDX_MCLK_SEL && hit)
        mclk_sel <= pwdata[7:0];
    end
  end

  // read word chosen in the setup phase
  always_comb
  begin
    rd_word = 8'h00;
    if (idx == `AMCG_IDX_PLL_CTRL)
      rd_word = pll_ctrl;
    else if (idx == `AMCG_IDX_MCLK_SEL)
      rd_word = mclk_sel;
    else if (idx == `AMCG_IDX_STATUS)
    begin
      rd_word[`AMCG_ST_LOCK_BIT] = locked;
      rd_word[`AMCG_ST_SLOW_BIT] = slow_clock;
      rd_word[`AMCG_ST_BAND_LO +: 2] = band;
      rd_word[`AMCG_ST_MULT_LO +: 2] = mult;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      prdata <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata <= (hit && !pwrite) ? {24'h00_0000, rd_word} : 32'h0000_0000;
      err_q <= !hit;
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_q;

  //--------------------------------------------------------------
  // assertions
  //--------------------------------------------------------------

  sequence seq_edge_seen;
    bclk_edge && resetn;
  endsequence
  sequence seq_x4_fall;
    $fell(tog4) ##0 locked;
  endsequence
  a_mclk_off_dis: assert property (@(posedge clock) disable iff (!resetn)
    !pll_enable |-> ##2 !mclk) else $error("master clock active with loop disabled");
  a_default_ratio: assert property (@(posedge clock) disable iff (!resetn)
    !mclk_sel[`AMCG_SEL_OVR_BIT] |-> mult == 2'h1)
    else $error("ratio not two without override");
  a_field_base: assert property (@(posedge clock) disable iff (!resetn)
    mclk_sel[`AMCG_SEL_OVR_BIT] && mclk_sel[6:4] == {1'b0, band} |-> mult == 2'h0)
    else $error("base code not taken as x1");
  a_top_band_x4: assert property (@(posedge clock) disable iff (!resetn)
    mclk_sel[7:4] == 4'he && band == amcg_pkg::BAND_TOP |-> mult == 2'h2)
    else $error("top band code not x4");
  a_x4_divides: assert property (@(posedge clock) disable iff (!resetn)
    seq_x4_fall |-> cnt2 == $past(cnt2) + 2'h1)
    else $error("divider missed an x4 period");
  a_mclk_follows: assert property (@(posedge clock) disable iff (!resetn)
    locked && mult == 2'h2 ##1 locked |-> mclk == $past(tog4))
    else $error("x4 master clock not following divider");
  a_data_retime: assert property (@(posedge clock) disable iff (!resetn)
    seq_edge_seen |=> data_retimed == $past(data_link))
    else $error("data not re-timed on bit clock edge");
  a_stop_unlocks: assert property (@(posedge clock) disable iff (!resetn)
    locked && timeout && pll_enable |=> state == amcg_pkg::ST_ACQUIRE ##1 !mclk)
    else $error("lock kept after bit clock stopped");

endmodule : amcg_top

// ==== testbench/amcg_codec_model.sv ====
// downstream codec model: counts master clock edges per bit clock period
// assumes mclk and bclk_out are registered on clock, so sampling on clock is exact
`timescale 1ns/1ns
module amcg_codec_model (
  input wire logic clock, // system clock for sampling
  input wire logic resetn, // synchronous reset, active low
  input wire logic mclk, // master clock from the block
  input wire logic bclk_out, // cleaned bit clock from the block
  output int ratio, // master clock rises in the last bit period
  output int periods, // bit clock periods seen
  output int mclk_rises // master clock rises seen
);
  logic last_m;
  logic last_b;
  int cnt;
  // --------------------------------------------------------------
  // edge counting
  // --------------------------------------------------------------
  // an mclk rise aligned with a bclk rise opens the new period
  always_ff @(posedge clock)
  begin
    last_m <= mclk;
    last_b <= bclk_out;
    if (!resetn)
    begin
      cnt <= 0;
      ratio <= 0;
      periods <= 0;
      mclk_rises <= 0;
    end
    else
    begin
      if (mclk && !last_m)
        mclk_rises <= mclk_rises + 1;
      if (bclk_out && !last_b)
      begin
        ratio <= cnt;
        periods <= periods + 1;
        cnt <= (mclk && !last_m) ? 1 : 0;
      end
      else if (mclk && !last_m)
        cnt <= cnt + 1;
    end
  end
endmodule : amcg_codec_model

// ==== testbench/audio_master_clock_gen_bench.sv ====
// bench for the audio master clock generator
// assumes a bit clock of 8 MHz, which falls in the top rate band
`timescale 1ns/1ns
`include "amcg_cfg.svh"
module audio_master_clock_gen_bench;
  logic clock = 1'b0, resetn = 1'b0, link_clock = 1'b0, audio_data = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, mclk, bclk_out, data_out;
  logic [31:0] prdata, rd;
  logic err, link_stop = 1'b0, last_data = 1'b0, last_bclk = 1'b0;
  logic [2:0] code;
  int failures = 0, compares = 0, seed = 36572, link_half = 62, m, i, n;
  int ratio, periods, mclk_rises, data_moves = 0;

  // --------------------------------------------------------------
  // clocks and stimulus
  // --------------------------------------------------------------
  always #2 clock = ~clock;
  // bit clock 125 ns, offset from the system clock
  initial
  begin
    #1;
    forever
    begin
      #(link_half) link_clock = link_clock ^ !link_stop;
      #(link_half + 1) link_clock = link_clock ^ !link_stop;
    end
  end
  always @(posedge clock) audio_data <= 1'($random(seed));

  // re-timed data may only change where the clean bit clock falls
  always @(posedge clock)
  begin
    last_data <= data_out;
    last_bclk <= bclk_out;
    if (resetn && data_out !== last_data)
    begin
      data_moves <= data_moves + 1;
      check("data on bclk fall", {30'h0, last_bclk, bclk_out}, 32'h2);
    end
  end

  amcg_top #(.TIMEOUT_CYC(500)) amcg_top_inst (.clock(clock), .resetn(resetn),
    .link_clock(link_clock), .audio_data(audio_data), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .mclk(mclk), .bclk_out(bclk_out),
    .data_out(data_out));
  amcg_codec_model amcg_codec_model_inst (.clock(clock), .resetn(resetn), .mclk(mclk),
    .bclk_out(bclk_out), .ratio(ratio), .periods(periods), .mclk_rises(mclk_rises));

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one apb transfer, setup then access until pready
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] st);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    pstrb <= st;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pready !== 1'b1 && k < 100);
    rd = prdata;
    err = pslverr;
    if (k >= 100)
      check("pready", 32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_periods(input int k);
    int start, c;
    start = periods;
    c = 0;
    while (periods < start + k && c < 5000)
    begin
      @(posedge clock);
      c++;
    end
    if (c >= 5000)
      check("bit clock periods", 32'h0, 32'h1);
  endtask : wait_periods

  // expected multiplier log2 in the top band, base code 011
  function automatic logic [1:0] exp_mult(input logic [2:0] c);
    if (c >= 3'h3 && c <= 3'h5)
      return 2'(c - 3'h3);
    if (c == `AMCG_CODE_TOP_X4)
      return 2'h2;
    return `AMCG_MULT_X2;
  endfunction : exp_mult

  task conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // watchdog
  initial
  begin
    #120000;
    failures++;
    conclude();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    // three cycles, the block stretches reset for its bit clock side
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    apb(1'b0, `AMCG_IDX_PLL_CTRL, 32'h0, 4'h0);
    check("pll_ctrl reset", rd, 32'h00);
    apb(1'b0, `AMCG_IDX_MCLK_SEL, 32'h0, 4'h0);
    check("mclk_sel reset", rd, 32'h10);
    apb(1'b0, 8'h55, 32'h0, 4'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    n = 0;
    do
    begin
      apb(1'b0, `AMCG_IDX_STATUS, 32'h0, 4'h0);
      n++;
    end
    while (rd[`AMCG_ST_LOCK_BIT] !== 1'b1 && n < 1000);
    check("locked", rd[`AMCG_ST_LOCK_BIT], 1'b1);
    wait_periods(3);
    check("default ratio", ratio, 2);
    check("default mult", rd[5:4], `AMCG_MULT_X2);
    // base code written with the override clear is ignored
    apb(1'b1, `AMCG_IDX_MCLK_SEL, ({$random(seed)} & 32'hffffff00) | 32'h00000030, 4'h1);
    wait_periods(3);
    check("no override ratio", ratio, 2);
    apb(1'b1, `AMCG_IDX_MCLK_SEL, 32'h000000b0, 4'h0);
    apb(1'b0, `AMCG_IDX_MCLK_SEL, 32'h0, 4'h0);
    check("strobe off", rd, 32'h30);
    // every code, then random ones
    for (i = 0; i < 14; i++)
    begin
      code = (i < 8) ? 3'(i) : 3'($random(seed));
      apb(1'b1, `AMCG_IDX_MCLK_SEL, 32'h00000080, 4'h1);
      apb(1'b1, `AMCG_IDX_MCLK_SEL, {$random(seed) % 256, 1'b1, code, 4'h0} & 32'h000000ff,
        4'hf);
      apb(1'b0, `AMCG_IDX_MCLK_SEL, 32'h0, 4'h0);
      check("mclk_sel readback", rd, {24'h0, 1'b1, code, 4'h0});
      wait_periods(3);
      apb(1'b0, `AMCG_IDX_STATUS, 32'h0, 4'h0);
      check("status mult", rd[5:4], exp_mult(code));
      check("codec ratio", ratio, 1 << exp_mult(code));
    end
    // stopped bit clock drops lock and the master clock
    link_stop = 1'b1;
    repeat (700) @(posedge clock);
    m = mclk_rises;
    repeat (100) @(posedge clock);
    check("mclk rises stopped", mclk_rises, m);
    apb(1'b0, `AMCG_IDX_STATUS, 32'h0, 4'h0);
    check("lock lost", rd[`AMCG_ST_LOCK_BIT], 1'b0);
    link_stop = 1'b0;
    // disabled loop gives no master clock
    apb(1'b1, `AMCG_IDX_PLL_CTRL, 32'h00000080, 4'h1);
    repeat (4) @(posedge clock);
    m = mclk_rises;
    repeat (300) @(posedge clock);
    check("mclk rises off", mclk_rises, m);
    check("mclk off", mclk, 1'b0);
    // slow bit clock is flagged, host turns the loop off
    apb(1'b1, `AMCG_IDX_PLL_CTRL, 32'h00000000, 4'h1);
    link_half = 600;
    n = 0;
    do
    begin
      apb(1'b0, `AMCG_IDX_STATUS, 32'h0, 4'h0);
      n++;
    end
    while (rd[`AMCG_ST_SLOW_BIT] !== 1'b1 && n < 3000);
    check("slow flag", rd[`AMCG_ST_SLOW_BIT], 1'b1);
    apb(1'b1, `AMCG_IDX_PLL_CTRL, 32'h00000080, 4'h1);
    link_half = 62;
    check("data moves", data_moves > 0, 1'b1);
    conclude();
  end
endmodule : audio_master_clock_gen_bench
